// ### pkg/osd_router_params.svh
// register map, field positions and reset values of the osd channel output router
`ifndef OSD_ROUTER_PARAMS_SVH
`define OSD_ROUTER_PARAMS_SVH

`define OSD_CTRL_OFS 12'h000
`define OSD_ROUTE_OFS 12'h004
`define OSD_STAT_OFS 12'h008
`define OSD_ADDR_W 12

// control register fields
`define OSD_CTRL_OPT_LSB 0
`define OSD_CTRL_3BLK_BIT 2
`define OSD_CTRL_DISP_LSB 4
`define OSD_CTRL_BG_LSB 8
`define OSD_CTRL_W 11
// option B, composite pin mode, all channels displayed, backgrounds off
`define OSD_CTRL_RST 11'h071

// route register: low bits of rows 0..11 at 11:0, high bits at 27:16
`define OSD_ROUTE_HI_LSB 16
`define OSD_ROUTE_RST 32'h0000_0000

// column where the right half of a row starts
`define OSD_HALF_COL 5'h0c
`define OSD_ROWS 12

`endif

// ### pkg/osd_router_pkg.sv
// types shared by the osd channel output router
package osd_router_pkg;

  typedef enum logic [1:0] {
    OPT_A,
    OPT_B,
    OPT_C,
    OPT_RSVD
  } route_opt_e;

  // one dot of the character stream
  typedef struct packed {
    logic valid;
    logic [3:0] row;
    logic [4:0] col;
    logic red;
    logic green;
    logic blue;
    logic second_mark;
    logic bg_area;
  } dot_in_s;

  // routed outputs, background signals alongside the characters
  typedef struct packed {
    logic red_char_out;
    logic green_char_out;
    logic blue_char_out;
    logic composite_char_out_a;
    logic composite_char_out_b;
    logic bg_rgb;
    logic bg_a;
    logic bg_b;
  } dot_out_s;

  // per-channel switches: index 0 rgb, 1 composite a, 2 composite b
  typedef logic [2:0] chan_mask_t;

endpackage

// ### core/osd_channel_output_router.sv
// osd channel output router: routes character dots to rgb and two composite outputs
//
// Functional notes
// - option B, bits 00: composite A carries all rows, composite B held low.
// - option B, hi 0 lo 1: A all rows, B that row's second-channel characters.
// - composite A character is OR of red, green, blue minus second-channel cells.
// - composite A background only outside second-channel cells.
// - composite B background only inside second-channel cells.
// - option C, bits 00: A gets columns 0-27, B held low.
// - option C, bits 01: A columns 0-11, B second-channel columns 12-27.
// - option C, bits 10: A columns 12-27, B second-channel columns 0-11.
// - option C, bits 11: A held low, B second-channel columns 0-27.
// - second-channel characters never on rgb or A; backgrounds follow area rules.
// - character display switchable per channel on top of routing.
// - background enable switchable per channel.
// - option A, low bit 0: A carries row's characters except second-channel ones.
// - option A, low bit 1: A held low for that row.
// - option A: B carries second-channel characters only where low bit is 1.
// - option B: A carries every row regardless of routing bits.
// - option B: B carries no characters on rows with low bit 0.
// - second-channel marking is per cell, independent of row routing bits.
// - routing option resets to B.
// - routing has no effect in three-blanking pin mode.
//
// The register offsets and register access over APB are this design's own decisions.
`include "osd_router_params.svh"

module osd_channel_output_router #(
  parameter int ROWS = `OSD_ROWS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`OSD_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // dot stream in
  input osd_router_pkg::dot_in_s i_dot,
  // routed dots out
  output osd_router_pkg::dot_out_s o_dot
);
  import osd_router_pkg::*;

  logic [`OSD_CTRL_W-1:0] ctrl_r;
  logic [ROWS-1:0] route_lo_r;
  logic [ROWS-1:0] route_hi_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  dot_out_s dot_r;
  dot_out_s dot_nxt;

  // ---------------- apb decode ----------------
  wire setup_ph = i_psel & ~i_penable;
  wire access_ph = i_psel & i_penable & pready_r;
  wire hit_ctrl = (i_paddr == `OSD_CTRL_OFS);
  wire hit_route = (i_paddr == `OSD_ROUTE_OFS);
  wire hit_stat = (i_paddr == `OSD_STAT_OFS);
  wire mapped = hit_ctrl | hit_route | hit_stat;
  // status is read only; a write to it is refused like an unmapped one
  wire bad_acc = ~mapped | (hit_stat & i_pwrite);
  wire wr_ctrl = access_ph & i_pwrite & hit_ctrl;
  wire wr_route = access_ph & i_pwrite & hit_route;

  // byte lanes merged over the current value
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] ctrl_word = {{(32-`OSD_CTRL_W){1'b0}}, ctrl_r};
  wire [31:0] route_word = {{(16-ROWS){1'b0}}, route_hi_r, {(16-ROWS){1'b0}}, route_lo_r};
  wire [31:0] stat_word = {16'h0000, 3'h0, i_dot.col, i_dot.row, 1'b0, dot_r.composite_char_out_a,
                           dot_r.composite_char_out_b, i_dot.valid};
  wire [31:0] ctrl_wr = merge(ctrl_word, i_pwdata, i_pstrb);
  wire [31:0] route_wr = merge(route_word, i_pwdata, i_pstrb);
  wire [31:0] rd_sel = hit_ctrl ? ctrl_word :
                       hit_route ? route_word :
                       hit_stat ? stat_word : 32'h0000_0000;

  // read data and error are captured in the setup cycle so they leave a flop
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_ph) begin
        prdata_r <= i_pwrite ? 32'h0000_0000 : rd_sel;
        pslverr_r <= bad_acc;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= `OSD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= ctrl_wr[`OSD_CTRL_W-1:0];
    end
  end

  // each row has its own bit pair, so any row can be rerouted alone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      route_lo_r <= ROWS'(`OSD_ROUTE_RST);
      route_hi_r <= ROWS'(`OSD_ROUTE_RST);
    end else if (wr_route) begin
      route_lo_r <= route_wr[ROWS-1:0];
      route_hi_r <= route_wr[`OSD_ROUTE_HI_LSB +: ROWS];
    end
  end

  // ---------------- routing ----------------
  wire [1:0] opt_raw = ctrl_r[`OSD_CTRL_OPT_LSB +: 2];
  // reserved option code behaves as option B
  wire route_opt_e opt = (opt_raw == 2'h3) ? OPT_B : route_opt_e'(opt_raw);
  wire three_blk = ctrl_r[`OSD_CTRL_3BLK_BIT];
  wire chan_mask_t disp_en = ctrl_r[`OSD_CTRL_DISP_LSB +: 3];
  wire chan_mask_t bg_en = ctrl_r[`OSD_CTRL_BG_LSB +: 3];

  // rows past the last one never route anything to composite B
  wire row_ok = (i_dot.row < 4'(ROWS));
  wire lo = row_ok & route_lo_r[i_dot.row];
  wire hi = row_ok & route_hi_r[i_dot.row];
  wire left_half = (i_dot.col < `OSD_HALF_COL);

  wire a_en_opt_a = ~lo;
  wire b_en_opt_a = lo;
  wire a_en_opt_b = 1'b1;
  wire b_en_opt_b = lo;
  // half-row split: a and b take complementary halves
  wire a_en_opt_c = hi ? (~lo & ~left_half) : (~lo | left_half);
  wire b_en_opt_c = hi ? (lo | left_half) : (lo & ~left_half);

  logic a_en;
  logic b_en;
  always_comb begin
    case (opt)
      OPT_A: begin
        a_en = a_en_opt_a;
        b_en = b_en_opt_a;
      end
      OPT_C: begin
        a_en = a_en_opt_c;
        b_en = b_en_opt_c;
      end
      default: begin
        a_en = a_en_opt_b;
        b_en = b_en_opt_b;
      end
    endcase
    if (three_blk) begin
      a_en = 1'b1;
      b_en = 1'b0;
    end
  end

  wire dots = i_dot.red | i_dot.green | i_dot.blue;
  wire mark = i_dot.second_mark;
  wire v = i_dot.valid;
  wire rgb_ok = v & ~mark & disp_en[0];

  always_comb begin
    dot_nxt.red_char_out = rgb_ok & i_dot.red;
    dot_nxt.green_char_out = rgb_ok & i_dot.green;
    dot_nxt.blue_char_out = rgb_ok & i_dot.blue;
    dot_nxt.composite_char_out_a = v & dots & ~mark & a_en & disp_en[1];
    dot_nxt.composite_char_out_b = v & dots & mark & b_en & disp_en[2] & ~three_blk;
    dot_nxt.bg_rgb = v & i_dot.bg_area & ~mark & bg_en[0];
    dot_nxt.bg_a = v & i_dot.bg_area & ~mark & bg_en[1];
    // background of b does not depend on the row routing bits
    dot_nxt.bg_b = v & i_dot.bg_area & mark & bg_en[2];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dot_r <= '0;
    end else begin
      dot_r <= dot_nxt;
    end
  end

  assign o_dot = dot_r;
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;

endmodule

// ### tb/osd_router_assertions.sv
// concurrent checks on the osd channel output router ports
`include "osd_router_params.svh"
module osd_router_assertions (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [`OSD_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input osd_router_pkg::dot_in_s i_dot,
  input osd_router_pkg::dot_out_s o_dot
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_marked;
    $past(i_dot.valid) && $past(i_dot.second_mark);
  endsequence
  sequence s_plain;
    $past(i_dot.valid) && !$past(i_dot.second_mark);
  endsequence
  property p_rgb_plain;
    o_dot.red_char_out |-> s_plain ##0 $past(i_dot.red);
  endproperty
  a_rgb_plain: assert property (p_rgb_plain) else $error("red char from marked or dark dot");
  property p_green_plain;
    o_dot.green_char_out |-> s_plain ##0 $past(i_dot.green);
  endproperty
  a_green_plain: assert property (p_green_plain) else $error("green char from marked or dark dot");
  property p_comp_a;
    o_dot.composite_char_out_a |-> s_plain ##0 ($past(i_dot.red) || $past(i_dot.green) || $past(i_dot.blue));
  endproperty
  a_comp_a: assert property (p_comp_a) else $error("composite a char without plain lit dot");
  property p_comp_b;
    o_dot.composite_char_out_b |-> s_marked ##0 ($past(i_dot.red) || $past(i_dot.green) || $past(i_dot.blue));
  endproperty
  a_comp_b: assert property (p_comp_b) else $error("composite b char without marked lit dot");
  property p_bg_a;
    o_dot.bg_a |-> s_plain ##0 $past(i_dot.bg_area);
  endproperty
  a_bg_a: assert property (p_bg_a) else $error("composite a background inside marked cell");
  property p_bg_b;
    o_dot.bg_b |-> s_marked ##0 $past(i_dot.bg_area);
  endproperty
  a_bg_b: assert property (p_bg_b) else $error("composite b background outside marked cell");
  property p_bg_rgb;
    o_dot.bg_rgb |-> s_plain ##0 $past(i_dot.bg_area);
  endproperty
  a_bg_rgb: assert property (p_bg_rgb) else $error("rgb background inside marked cell");
  property p_unmapped;
    i_psel && !i_penable && i_paddr > 12'h008 |=> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule
bind osd_channel_output_router osd_router_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_dot(i_dot), .o_dot(o_dot));

// ### tb/osd_dot_source.sv
// dot stream source standing in for the character generator
module osd_dot_source (
  input wire logic i_clk,
  input osd_router_pkg::dot_in_s i_next,
  output osd_router_pkg::dot_in_s o_dot
);
  timeunit 1ns;
  timeprecision 1ps;
  // one dot per clock, launched on the edge like a registered generator
  always @(posedge i_clk) o_dot <= i_next;
endmodule

// ### tb/test_osd_channel_output_router.sv
// self-checking bench for the osd channel output router
`include "osd_router_params.svh"
module test_osd_channel_output_router;
  timeunit 1ns;
  timeprecision 1ps;
  import osd_router_pkg::*;
  logic i_clk = 0, i_nrst = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata, prdata, ctrl, route;
  dot_in_s dot, nxt = '0, d;
  dot_out_s dout, m;
  int mismatches = 0, checks = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  osd_dot_source src (.i_clk(i_clk), .i_next(nxt), .o_dot(dot));
  osd_channel_output_router uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_dot(dot), .o_dot(dout));
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v, input logic err);
    @(posedge i_clk);
    psel <= 1;
    pwr <= wr;
    addr <= a;
    wdata <= v;
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdata = prdata;
    cmp(pslverr, err);
    psel <= 0;
    pen <= 0;
  endtask
  // reference routing worked out from ctrl, route and the dot
  function automatic dot_out_s model(input logic [31:0] c, input logic [31:0] r, input dot_in_s x);
    dot_out_s o;
    logic lo, hi, rh, lit, a_en, b_en;
    lo = x.row < 12 && r[x.row];
    hi = x.row < 12 && r[16 + x.row];
    rh = x.col >= 12;
    lit = x.red | x.green | x.blue;
    a_en = c[1:0] == 2'd0 ? !lo : c[1:0] == 2'd2 ? !(hi & lo) && (hi == lo || hi == rh) : 1'b1;
    b_en = c[1:0] == 2'd2 ? (hi | lo) && (hi == lo || lo == rh) : lo;
    o.red_char_out = x.red & ~x.second_mark & c[4];
    o.green_char_out = x.green & ~x.second_mark & c[4];
    o.blue_char_out = x.blue & ~x.second_mark & c[4];
    o.composite_char_out_a = lit & ~x.second_mark & (a_en | c[2]) & c[5];
    o.composite_char_out_b = lit & x.second_mark & b_en & ~c[2] & c[6];
    o.bg_rgb = x.bg_area & ~x.second_mark & c[8];
    o.bg_a = x.bg_area & ~x.second_mark & c[9];
    o.bg_b = x.bg_area & x.second_mark & c[10];
    return x.valid ? o : '0;
  endfunction
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'had11));
    repeat (12) @(posedge i_clk);
    i_nrst <= 1;
    apb(0, `OSD_CTRL_OFS, 0, 0);
    cmp(rdata, 32'h071);
    apb(0, `OSD_ROUTE_OFS, 0, 0);
    cmp(rdata, 0);
    apb(1, `OSD_STAT_OFS, 32'hffff, 1);
    apb(0, 12'h00c, 0, 1);
    cmp(rdata, 0);
    for (int k = 0; k < 64; k++) begin
      ctrl = $urandom & 32'h770;
      ctrl[1:0] = k[1:0];
      ctrl[2] = k[3:2] == 2'b11;
      if (k < 16) ctrl = ctrl | 32'h770;
      route = $urandom & 32'h0fff_0fff;
      apb(1, `OSD_CTRL_OFS, ctrl, 0);
      apb(1, `OSD_ROUTE_OFS, route, 0);
      apb(0, `OSD_ROUTE_OFS, 0, 0);
      cmp(rdata, route);
      repeat (24) begin
        d = dot_in_s'(14'($urandom));
        d.valid = ($urandom % 8) != 0;
        d.row = 4'($urandom_range(13, 0));
        d.col = 5'($urandom_range(27, 0));
        @(posedge i_clk);
        nxt <= d;
        repeat (2) @(posedge i_clk);
        #1;
        cmp(32'(dout), 32'(model(ctrl, route, d)));
      end
      // status shows the live dot and the last routed composite pair
      m = model(ctrl, route, d);
      apb(0, `OSD_STAT_OFS, 0, 0);
      cmp(rdata, {19'h0, d.col, d.row, 1'b0, m.composite_char_out_a, m.composite_char_out_b, d.valid});
    end
    report_and_stop();
  end
endmodule
